/* core/bxb_arb_if.sv */
// arbitration and phase-tracking signals between the master engine and the arbiter
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface bxb_arb_if #(
   parameter int NM = 3
);
   logic [NM-1:0] req;
   logic [NM-1:0] gnt;
   logic start;
   logic nop_drive;
   logic dp_end;
   logic bus_bip;
   logic bus_wait;
   logic bus_error;

   modport arb (
      input req,
      input bus_bip,
      input bus_wait,
      input bus_error,
      output gnt,
      output start,
      output nop_drive,
      output dp_end
   );

   modport mst (
      output req,
      output bus_bip,
      output bus_wait,
      output bus_error,
      input gnt,
      input start,
      input nop_drive,
      input dp_end
   );
endinterface

/* core/bxb_arbiter.sv */
// central arbiter: start, grants, phase tracking and the no_operation_cycle drive
// assumes bus inputs are the resolved wire levels, synchronous to clk
`timescale 1ns/100ps
module bxb_arbiter #(
   parameter bit PIPELINED = 1'b0,
   parameter int NM = 3
) (
   input wire logic clk,
   input wire logic rst,
   bxb_arb_if.arb arb
);
   import bxb_pkg::*;

   bxb_arb_state_t state_ff;
   bxb_arb_state_t nxt_state;
   logic start_ff;
   logic nxt_start;
   logic anop_ff;
   logic nxt_anop;
   logic dnop_ff;
   logic nxt_dnop;
   logic [NM-1:0] gnt_ff;
   logic [NM-1:0] pick;
   logic data_last;
   logic dp_end;

   // -----------------------------------------------------------------
   // end of data phase
   // -----------------------------------------------------------------
   assign data_last = arb.bus_error | (~arb.bus_bip & ~arb.bus_wait);
   // pipelined: an empty data phase after a no_operation_cycle lasts one cycle; unpipelined skips the data phase
   assign dp_end = PIPELINED ? (state_ff == ARB_PIPE && (dnop_ff || data_last))
                             : (state_ff == ARB_DATA && data_last);

   // -----------------------------------------------------------------
   // grants, fixed priority, lowest index wins
   // -----------------------------------------------------------------
   always_comb begin
      pick = '0;
      for (int i = NM - 1; i >= 0; i--) begin
         if (arb.req[i]) begin
            pick = '0;
            pick[i] = 1'b1;
         end
      end
   end

   always_ff @(negedge clk or posedge rst) begin
      if (rst) begin
         gnt_ff <= '0;
      end else if (state_ff == ARB_RESET) begin
         gnt_ff <= '0;
      end else if (PIPELINED || start_ff) begin
         gnt_ff <= pick;
      end else begin
         gnt_ff <= '0;
      end
   end

   // -----------------------------------------------------------------
   // phase sequencing
   // -----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_start = 1'b0;
      nxt_anop = anop_ff;
      nxt_dnop = dnop_ff;
      case (state_ff)
         ARB_RESET: begin
            nxt_state = PIPELINED ? ARB_PIPE : ARB_ARBITRATE;
            nxt_start = 1'b1;
            nxt_anop = 1'b1;
            nxt_dnop = 1'b1;
         end
         ARB_ARBITRATE: begin
            nxt_state = ARB_ADDRESS;
            nxt_anop = ~|gnt_ff;
         end
         ARB_ADDRESS: begin
            if (anop_ff) begin
               nxt_state = ARB_ARBITRATE;
               nxt_start = 1'b1;
            end else begin
               nxt_state = ARB_DATA;
            end
         end
         ARB_DATA: begin
            if (dp_end) begin
               nxt_state = ARB_ARBITRATE;
               nxt_start = 1'b1;
            end
         end
         ARB_PIPE: begin
            // one start opens arbitration, address and data together
            nxt_start = dp_end;
            if (dp_end) begin
               nxt_dnop = anop_ff;
               nxt_anop = ~|gnt_ff;
            end
         end
         default: begin
            nxt_state = ARB_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= ARB_RESET;
         start_ff <= RST_START;
         anop_ff <= 1'b1;
         dnop_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         start_ff <= nxt_start;
         anop_ff <= nxt_anop;
         dnop_ff <= nxt_dnop;
      end
   end

   assign arb.gnt = gnt_ff;
   assign arb.start = start_ff;
   assign arb.dp_end = dp_end;
   assign arb.nop_drive = anop_ff && (PIPELINED ? (state_ff == ARB_PIPE)
                                                : (state_ff == ARB_ADDRESS));
endmodule

/* core/bxb_host.sv */
// byte bus host: the central arbiter plus one bus master with a command port
// assumes every pin input is synchronous to SYS_CLK and is the resolved wire level;
// the wire itself is built outside from the _O and _OE outputs
`timescale 1ns/100ps

// What this block does
// - read byte captured only when wait low
// - more-bytes high until ready for last byte
// - release all lines after final cycle
// - error with wait low fails that byte
// - error ends data phase despite more-bytes
// - start high in arbitration, low otherwise
// - address group driven only in address phase
// - more-bytes driven in data, low at last
// - master drives data on writes only
// - all agents share one pipelining choice
// - pipelined mode overlaps three phases
// - pipelined arbiter arbitrates every cycle
// - pipelined start follows each data end
// - data ends on error or both low
// - pipelined: granted master holds address until data end
// - no grant means arbiter drives no-operation
// - pipelined lines need multiplexed ring or star
// - act on rising edge, grants falling
// - reset holds start and grants low
module bxb_host
   import bxb_pkg::*;
#(
   parameter bit PIPELINED = 1'b0,
   parameter int N_EXT = bxb_pkg::N_EXT_DEF
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_WRITE,
   input wire logic [bxb_pkg::ADDR_W-1:0] CMD_ADDR,
   input wire logic [bxb_pkg::SIZE_W-1:0] CMD_SIZE,
   input wire logic [bxb_pkg::MAX_BYTES*bxb_pkg::DATA_W-1:0] CMD_WDATA,
   output logic RSP_VALID,
   output logic RSP_ERROR,
   output logic [bxb_pkg::CNT_W-1:0] RSP_COUNT,
   output logic [bxb_pkg::MAX_BYTES*bxb_pkg::DATA_W-1:0] RSP_RDATA,
   input wire logic [N_EXT-1:0] EXT_REQ,
   output logic [N_EXT-1:0] EXT_GNT,
   output logic BUS_START,
   output logic [bxb_pkg::ADDR_W-1:0] BUS_ADDR_O,
   output logic [bxb_pkg::SIZE_W-1:0] BUS_SIZE_O,
   output logic BUS_READ_O,
   output logic BUS_WRITE_O,
   output logic BUS_ADDR_OE,
   input wire logic BUS_BIP_I,
   output logic BUS_BIP_O,
   output logic BUS_BIP_OE,
   input wire logic [bxb_pkg::DATA_W-1:0] BUS_DATA_I,
   output logic [bxb_pkg::DATA_W-1:0] BUS_DATA_O,
   output logic BUS_DATA_OE,
   input wire logic BUS_WAIT_I,
   input wire logic BUS_ERROR_I
);
   import bxb_pkg::*;

   localparam int NM = N_EXT + 1;
   localparam int WD_W = MAX_BYTES * DATA_W;

   // -----------------------------------------------------------------
   // arbiter
   // -----------------------------------------------------------------
   // one PIPELINED choice feeds both arbiter and master
   bxb_arb_if #(.NM(NM)) arb_bus ();

   bxb_arbiter #(
      .PIPELINED(PIPELINED),
      .NM(NM)
   ) u_arbiter (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .arb(arb_bus.arb)
   );

   bxb_mst_state_t mst_ff;
   bxb_mst_state_t nxt_mst;
   logic own_req;
   logic own_gnt;
   logic take_addr;
   logic addr_done;
   logic data_done;
   logic byte_ok;
   logic bip_drv;

   assign arb_bus.req = {EXT_REQ, own_req};
   assign arb_bus.bus_bip = BUS_BIP_I;
   assign arb_bus.bus_wait = BUS_WAIT_I;
   assign arb_bus.bus_error = BUS_ERROR_I;
   assign own_gnt = arb_bus.gnt[0];
   assign EXT_GNT = arb_bus.gnt[NM-1:1];
   assign BUS_START = arb_bus.start;

   // -----------------------------------------------------------------
   // command latch
   // -----------------------------------------------------------------
   logic wr_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [SIZE_W-1:0] size_ff;
   logic [WD_W-1:0] wdata_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] last_idx;

   assign CMD_READY = (mst_ff == M_IDLE);

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wr_ff <= 1'b0;
         addr_ff <= NOP_ADDR;
         size_ff <= NOP_SIZE;
      end else if (CMD_VALID && CMD_READY) begin
         wr_ff <= CMD_WRITE;
         addr_ff <= CMD_ADDR;
         size_ff <= CMD_SIZE;
      end
   end

   // size code n means 2**n bytes
   assign last_idx = (CNT_ONE << size_ff) - CNT_ONE;

   // -----------------------------------------------------------------
   // master sequencing
   // -----------------------------------------------------------------
   assign own_req = (mst_ff == M_REQ);
   // unpipelined: grant seen at the end of arbitration; pipelined: at a data end
   assign take_addr = own_req && own_gnt && (!PIPELINED || arb_bus.dp_end);
   assign addr_done = PIPELINED ? arb_bus.dp_end : 1'b1;
   assign bip_drv = (cnt_ff != last_idx);
   assign byte_ok = !BUS_WAIT_I && !BUS_ERROR_I;
   assign data_done = BUS_ERROR_I || (!bip_drv && !BUS_WAIT_I);

   always_comb begin
      nxt_mst = mst_ff;
      case (mst_ff)
         M_IDLE: begin
            if (CMD_VALID) begin
               nxt_mst = M_REQ;
            end
         end
         M_REQ: begin
            if (take_addr) begin
               nxt_mst = M_ADDR;
            end
         end
         M_ADDR: begin
            if (addr_done) begin
               nxt_mst = M_DATA;
            end
         end
         M_DATA: begin
            // error ends the phase even with more bytes still pending
            if (data_done) begin
               nxt_mst = M_IDLE;
            end
         end
         default: begin
            nxt_mst = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mst_ff <= M_IDLE;
      end else begin
         mst_ff <= nxt_mst;
      end
   end

   // -----------------------------------------------------------------
   // byte counter and write shifter
   // -----------------------------------------------------------------
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cnt_ff <= CNT_ZERO;
      end else if (mst_ff != M_DATA) begin
         cnt_ff <= CNT_ZERO;
      end else if (byte_ok && bip_drv) begin
         cnt_ff <= cnt_ff + CNT_ONE;
      end
   end

   // byte 0 goes first; the low byte of the shifter is always on the bus
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wdata_ff <= '0;
      end else if (CMD_VALID && CMD_READY) begin
         wdata_ff <= CMD_WDATA;
      end else if (mst_ff == M_DATA && byte_ok) begin
         wdata_ff <= {{DATA_W{1'b0}}, wdata_ff[WD_W-1:DATA_W]};
      end
   end

   // -----------------------------------------------------------------
   // read capture and response
   // -----------------------------------------------------------------
   logic [WD_W-1:0] rdata_ff;
   logic rsp_valid_ff;
   logic rsp_error_ff;
   logic [CNT_W-1:0] rsp_count_ff;

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_ff <= '0;
      end else if (CMD_VALID && CMD_READY) begin
         rdata_ff <= '0;
      end else if (mst_ff == M_DATA && !wr_ff && byte_ok) begin
         // data lines are don't-care while wait is high
         rdata_ff[cnt_ff*DATA_W +: DATA_W] <= BUS_DATA_I;
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rsp_valid_ff <= 1'b0;
         rsp_error_ff <= 1'b0;
         rsp_count_ff <= CNT_ZERO;
      end else if (mst_ff == M_DATA && data_done) begin
         rsp_valid_ff <= 1'b1;
         // failed byte not counted; later bytes are abandoned
         rsp_error_ff <= BUS_ERROR_I;
         rsp_count_ff <= BUS_ERROR_I ? cnt_ff : cnt_ff + CNT_ONE;
      end else begin
         rsp_valid_ff <= 1'b0;
      end
   end

   assign RSP_VALID = rsp_valid_ff;
   assign RSP_ERROR = rsp_error_ff;
   assign RSP_COUNT = rsp_count_ff;
   assign RSP_RDATA = rdata_ff;

   // -----------------------------------------------------------------
   // pin drive
   // -----------------------------------------------------------------
   // the arbiter's zero drive and the master's drive never overlap, since the
   // arbiter only drives when nobody held a grant as the address phase began; in pipelined mode the
   // enables of different agents swap cycle to cycle, so the outside wire
   // must be a multiplexer, not a tristate net
   logic mst_addr;

   assign mst_addr = (mst_ff == M_ADDR);
   assign BUS_ADDR_OE = mst_addr || arb_bus.nop_drive;
   assign BUS_ADDR_O = mst_addr ? addr_ff : NOP_ADDR;
   assign BUS_SIZE_O = mst_addr ? size_ff : NOP_SIZE;
   assign BUS_READ_O = mst_addr && !wr_ff;
   assign BUS_WRITE_O = mst_addr && wr_ff;

   // more-bytes drops once the last byte is on offer
   assign BUS_BIP_OE = (mst_ff == M_DATA);
   assign BUS_BIP_O = (mst_ff == M_DATA) && bip_drv;
   assign BUS_DATA_OE = (mst_ff == M_DATA) && wr_ff;
   assign BUS_DATA_O = wdata_ff[DATA_W-1:0];

   // error and wait are never driven here; the slave owns them in data
   // phases, and after a no_operation_cycle it holds them low
endmodule

/* core/bxb_pkg.sv */
// shared constants and types of the byte bus host (arbiter plus one master)
// assumes a single rising-edge clock; grants are also updated on the falling edge
package bxb_pkg;

   // -----------------------------------------------------------------
   // bus geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int SIZE_W = 2;
   localparam int MAX_BYTES = 8;
   localparam int CNT_W = 4;
   localparam int N_EXT_DEF = 2;

   // -----------------------------------------------------------------
   // reset and idle values
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] NOP_ADDR = 16'h0000;
   localparam logic [SIZE_W-1:0] NOP_SIZE = 2'h0;
   localparam logic RST_START = 1'b0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   // -----------------------------------------------------------------
   // state encodings
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ARB_RESET     = 3'b000,
      ARB_ARBITRATE = 3'b001,
      ARB_ADDRESS   = 3'b010,
      ARB_DATA      = 3'b011,
      ARB_PIPE      = 3'b100
   } bxb_arb_state_t;

   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_REQ  = 2'b01,
      M_ADDR = 2'b10,
      M_DATA = 2'b11
   } bxb_mst_state_t;

endpackage

/* tb/bxb_host_sva.sv */
// checker on the host's pins; address-phase and grant-timing checks apply to the unpipelined bus only, the one-grant check to both
// assumes it is bound into bxb_host and sees resolved slave inputs
`timescale 1ns/100ps
module bxb_host_sva
   import bxb_pkg::*;
#(
   parameter bit PIPELINED = 1'b0,
   parameter int N_EXT = 2
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic RSP_VALID,
   input wire logic [N_EXT-1:0] EXT_GNT,
   input wire logic BUS_START,
   input wire logic [bxb_pkg::ADDR_W-1:0] BUS_ADDR_O,
   input wire logic [bxb_pkg::SIZE_W-1:0] BUS_SIZE_O,
   input wire logic BUS_READ_O,
   input wire logic BUS_WRITE_O,
   input wire logic BUS_ADDR_OE,
   input wire logic BUS_BIP_O,
   input wire logic BUS_BIP_OE,
   input wire logic [bxb_pkg::DATA_W-1:0] BUS_DATA_O,
   input wire logic BUS_DATA_OE,
   input wire logic BUS_WAIT_I,
   input wire logic BUS_ERROR_I
);
   logic dp_end;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);
   assign dp_end = BUS_BIP_OE && (BUS_ERROR_I || (!BUS_BIP_O && !BUS_WAIT_I));
   a_rst_quiet: assert property (disable iff (1'b0) SYS_RST |-> !BUS_START && EXT_GNT == '0
      && !BUS_ADDR_OE && !BUS_BIP_OE) else $error("bus active in reset");
   a_start_rise: assert property ($fell(SYS_RST) |=> BUS_START)
      else $error("no start after reset");
   a_addr_follow: assert property (!PIPELINED && BUS_ADDR_OE |->
      $past(BUS_START) ##1 !BUS_ADDR_OE) else $error("address phase misplaced");
   a_nop_zero: assert property (!BUS_READ_O && !BUS_WRITE_O |-> BUS_ADDR_O == '0
      && BUS_SIZE_O == '0) else $error("address group not zero");
   a_ext_hands: assert property (!PIPELINED && EXT_GNT != '0 |->
      BUS_START ##1 !BUS_ADDR_OE) else $error("grant outside start or bus taken");
   a_one_grant: assert property ($onehot0(EXT_GNT))
      else $error("several grants");
   a_data_hold: assert property (BUS_DATA_OE && BUS_WAIT_I && !BUS_ERROR_I |=>
      BUS_DATA_OE && $stable(BUS_DATA_O)) else $error("write byte moved in wait");
   a_bip_hold: assert property (BUS_BIP_OE && BUS_WAIT_I && !BUS_ERROR_I |=>
      BUS_BIP_OE && $stable(BUS_BIP_O)) else $error("more-bytes moved in wait");
   a_end_release: assert property (dp_end |=> BUS_START && !BUS_BIP_OE
      && !BUS_DATA_OE && RSP_VALID) else $error("no release at data end");
   c_err_end: cover property (dp_end && BUS_ERROR_I && BUS_BIP_O);
   c_wr_wait: cover property (BUS_DATA_OE && BUS_WAIT_I);
   c_ext_gnt: cover property (EXT_GNT != '0);
endmodule
bind bxb_host bxb_host_sva #(.PIPELINED(PIPELINED), .N_EXT(N_EXT)) bxb_host_sva_inst (
   .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .RSP_VALID(RSP_VALID), .EXT_GNT(EXT_GNT),
   .BUS_START(BUS_START),
   .BUS_ADDR_O(BUS_ADDR_O), .BUS_SIZE_O(BUS_SIZE_O), .BUS_READ_O(BUS_READ_O),
   .BUS_WRITE_O(BUS_WRITE_O), .BUS_ADDR_OE(BUS_ADDR_OE), .BUS_BIP_O(BUS_BIP_O),
   .BUS_BIP_OE(BUS_BIP_OE), .BUS_DATA_O(BUS_DATA_O), .BUS_DATA_OE(BUS_DATA_OE),
   .BUS_WAIT_I(BUS_WAIT_I), .BUS_ERROR_I(BUS_ERROR_I));

/* tb/bxb_host_tb.sv */
// bench: host against a memory slave model and a stand-in outside master
// assumes the main host unpipelined and a second host pipelined; undriven lines of the main host's bus flip each cycle
`timescale 1ns/100ps
module bxb_host_tb;
   import bxb_pkg::*;
   typedef struct packed {
      logic w;
      logic [15:0] ad;
      logic [1:0] sz;
      logic [3:0] nw;
      logic [3:0] ei;
      logic [3:0] cnt;
      logic er;
   } bxb_row_t;
   bxb_row_t rows [8] = '{'{1'b1, 16'h0010, 2'h3, 4'h0, 4'hf, 4'h8, 1'b0},
      '{1'b0, 16'h0010, 2'h3, 4'h2, 4'hf, 4'h8, 1'b0}, '{1'b1, 16'h0020, 2'h0, 4'h1, 4'hf, 4'h1, 1'b0},
      '{1'b0, 16'h0020, 2'h0, 4'h0, 4'hf, 4'h1, 1'b0}, '{1'b1, 16'h0030, 2'h2, 4'h0, 4'h2, 4'h2, 1'b1},
      '{1'b0, 16'h0030, 2'h2, 4'h1, 4'hf, 4'h4, 1'b0}, '{1'b0, 16'h00fe, 2'h1, 4'h0, 4'h0, 4'h0, 1'b1},
      '{1'b0, 16'h0040, 2'h3, 4'h0, 4'h7, 4'h7, 1'b1}};
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [15:0] cmd_addr = '0;
   logic [1:0] cmd_size = '0;
   logic [63:0] cmd_wdata = '0;
   logic [1:0] ext_req = '0;
   logic ext_aoe = 1'b0;
   logic ext_boe = 1'b0;
   logic [3:0] cfg_nw = '0;
   logic [3:0] cfg_ei = 4'hf;
   logic tgl = 1'b0;
   logic [7:0] shadow [256];
   int n_fail = 0;
   int checks_done = 0;
   logic cmd_ready, rsp_valid, rsp_error, bus_start, addr_oe, read_o, write_o;
   logic bip_o, bip_oe, data_oe, s_act, s_wt, s_err;
   logic [3:0] rsp_count;
   logic [63:0] rsp_rdata;
   logic [1:0] ext_gnt, size_o;
   logic [15:0] addr_o;
   logic [7:0] data_o, s_dat;
   logic p_cmd = 1'b0;
   logic p_rsp, p_err, p_bip_o, p_bip_oe;
   logic [3:0] p_cnt;
   logic [63:0] p_rdata;
   // nobody drives a released line, so it must never look stable
   wire logic rd_w = addr_oe ? read_o : ext_aoe | tgl;
   wire logic wr_w = addr_oe ? write_o : !ext_aoe && !tgl;
   wire logic [15:0] ad_w = addr_oe ? addr_o : ext_aoe ? 16'h0050 : {8{tgl, !tgl}};
   wire logic bip_w = bip_oe ? bip_o : ext_boe ? 1'b0 : tgl;
   wire logic [7:0] dat_w = data_oe ? data_o : (s_act && !s_wt) ? s_dat : {4{tgl, !tgl}};
   wire logic wt_w = s_act ? s_wt : tgl;
   wire logic er_w = s_act ? s_err : !tgl;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) tgl <= ~tgl;
   bxb_host #(.PIPELINED(1'b0), .N_EXT(2)) bxb_host_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
      .CMD_SIZE(cmd_size), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_ERROR(rsp_error),
      .RSP_COUNT(rsp_count), .RSP_RDATA(rsp_rdata), .EXT_REQ(ext_req), .EXT_GNT(ext_gnt),
      .BUS_START(bus_start), .BUS_ADDR_O(addr_o), .BUS_SIZE_O(size_o), .BUS_READ_O(read_o),
      .BUS_WRITE_O(write_o), .BUS_ADDR_OE(addr_oe), .BUS_BIP_I(bip_w), .BUS_BIP_O(bip_o),
      .BUS_BIP_OE(bip_oe), .BUS_DATA_I(dat_w), .BUS_DATA_O(data_o), .BUS_DATA_OE(data_oe),
      .BUS_WAIT_I(wt_w), .BUS_ERROR_I(er_w));
   bxb_slave_model bxb_slave_model_inst (.clk(sys_clk), .rst(sys_rst), .start(bus_start),
      .rd(rd_w), .wr(wr_w), .addr(ad_w), .bip(bip_w), .wdata(dat_w), .nwait(cfg_nw),
      .eidx(cfg_ei), .act(s_act), .wt(s_wt), .err(s_err), .rdata(s_dat));
   // second host, pipelined; its slave never waits or errs, and more-bytes
   // reads low whenever the host leaves it, as after a no_operation_cycle
   if (1'b1) begin : g_pipe
      bxb_host #(.PIPELINED(1'b1), .N_EXT(2)) bxb_host_inst (.SYS_CLK(sys_clk),
         .SYS_RST(sys_rst), .CMD_VALID(p_cmd), .CMD_READY(), .CMD_WRITE(cmd_write),
         .CMD_ADDR(cmd_addr), .CMD_SIZE(cmd_size), .CMD_WDATA(cmd_wdata), .RSP_VALID(p_rsp),
         .RSP_ERROR(p_err), .RSP_COUNT(p_cnt), .RSP_RDATA(p_rdata), .EXT_REQ(2'h0),
         .EXT_GNT(), .BUS_START(), .BUS_ADDR_O(), .BUS_SIZE_O(), .BUS_READ_O(),
         .BUS_WRITE_O(), .BUS_ADDR_OE(), .BUS_BIP_I(p_bip_oe & p_bip_o), .BUS_BIP_O(p_bip_o),
         .BUS_BIP_OE(p_bip_oe), .BUS_DATA_I(8'h3c), .BUS_DATA_O(), .BUS_DATA_OE(),
         .BUS_WAIT_I(1'b0), .BUS_ERROR_I(1'b0));
   end
   // ------
   // tasks
   // ------
   task automatic cmp_flag(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: word %h not %h", $time, got, exp);
      end
   endtask
   task automatic run(input bxb_row_t r, input logic [63:0] wd, input bit cut);
      logic [63:0] exp;
      int n;
      exp = '0;
      n = 0;
      @(negedge sys_clk);
      {cfg_nw, cfg_ei, cmd_write, cmd_addr, cmd_size} = {r.nw, r.ei, r.w, r.ad, r.sz};
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      if (cut) begin
         repeat (6) @(negedge sys_clk);
         return;
      end
      while (rsp_valid !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      cmp_flag(rsp_valid, 1'b1);
      for (int k = 0; k < 8; k++) begin
         if (k < r.cnt && r.w) begin
            shadow[8'(r.ad + k)] = wd[8*k +: 8];
         end else if (k < r.cnt) begin
            exp[8*k +: 8] = shadow[8'(r.ad + k)];
         end
      end
      cmp_word({60'h0, rsp_count}, {60'h0, r.cnt});
      cmp_flag(rsp_error, r.er);
      cmp_word(rsp_rdata, exp);
   endtask
   task automatic chk_rst;
      cmp_flag(bus_start, 1'b0);
      cmp_word({62'h0, ext_gnt}, 64'h0);
      cmp_flag(addr_oe | bip_oe | data_oe, 1'b0);
      cmp_flag(cmd_ready & !rsp_valid, 1'b1);
   endtask
   task automatic ext_xfer(input int b);
      int n;
      n = 0;
      @(negedge sys_clk);
      ext_req[b] <= 1'b1;
      while (ext_gnt[b] !== 1'b1 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      cmp_flag(ext_gnt[b], 1'b1);
      @(negedge sys_clk);
      ext_req[b] <= 1'b0;
      ext_aoe = 1'b1;
      @(negedge sys_clk);
      ext_aoe = 1'b0;
      ext_boe = 1'b1;
      while (bus_start !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      ext_boe = 1'b0;
      cmp_flag(bus_start, 1'b1);
   endtask
   task automatic stop_test;
      if (n_fail == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end
   initial begin
      for (int i = 0; i < 256; i++) begin
         shadow[i] = 8'(i) ^ 8'ha5;
      end
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_rst();
      sys_rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         run(rows[i], 64'hf0e1d2c3b4a59687 ^ {8{i[7:0]}}, 1'b0);
      end
      cfg_nw = 4'h1;
      cfg_ei = 4'hf;
      for (int b = 0; b < 2; b++) begin
         ext_xfer(b);
      end
      // reset lands in the middle of a stalled read burst
      run('{1'b0, 16'h0060, 2'h3, 4'hf, 4'hf, 4'h0, 1'b0}, 64'h0, 1'b1);
      sys_rst = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk_rst();
      sys_rst = 1'b0;
      run(rows[1], 64'h0, 1'b0);
      // pipelined host: a two-byte read behind a stream of no_operation_cycles
      begin : pipe_case
         int n;
         n = 0;
         @(negedge sys_clk);
         {cmd_write, cmd_size} = {1'b0, 2'h1};
         p_cmd = 1'b1;
         @(negedge sys_clk);
         p_cmd = 1'b0;
         while (p_rsp !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
         end
         cmp_flag(p_rsp, 1'b1);
         cmp_flag(p_err, 1'b0);
         cmp_word({60'h0, p_cnt}, 64'h2);
         cmp_word(p_rdata, 64'h3c3c);
      end
      stop_test();
   end
endmodule

/* tb/bxb_slave_model.sv */
// memory slave model that answers unpipelined data phases with set waits and errors
// assumes resolved wire levels at its inputs and the host's clock
`timescale 1ns/100ps
module bxb_slave_model
   import bxb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic rd,
   input wire logic wr,
   input wire logic [bxb_pkg::ADDR_W-1:0] addr,
   input wire logic bip,
   input wire logic [bxb_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] nwait,
   input wire logic [3:0] eidx,
   output logic act,
   output logic wt,
   output logic err,
   output logic [bxb_pkg::DATA_W-1:0] rdata
);
   logic [7:0] mem [256];
   logic st_d;
   logic isrd;
   logic [7:0] base;
   logic [3:0] k;
   logic [3:0] wc;
   // waits precede every byte, so each byte of a burst stalls alike
   assign wt = act && (wc < nwait);
   assign err = act && !wt && (k == eidx);
   assign rdata = mem[base + {4'h0, k}];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'ha5;
      end
   end
   always @(posedge clk) begin
      if (rst) begin
         st_d <= 1'b0;
         act <= 1'b0;
      end else begin
         st_d <= start;
         if (act && wt) begin
            wc <= wc + 4'h1;
         end else if (act) begin
            if (!isrd && !err) begin
               mem[base + {4'h0, k}] <= wdata;
            end
            wc <= 4'h0;
            k <= k + 4'h1;
            act <= bip && !err;
         end else if (st_d && (rd ^ wr)) begin
            act <= 1'b1;
            isrd <= rd;
            base <= addr[7:0];
            k <= 4'h0;
            wc <= 4'h0;
         end
      end
   end
endmodule
